// File: verilog/ext_dp_pkg.sv
package ext_dp_pkg;

    localparam int DATA_W = 8;
    localparam int MEM_AW = 9;
    localparam int HOST_AW = 10;

    // host port map: memory bytes below the special words
    localparam logic [HOST_AW-1:0] HOST_ACC_ADDR = 10'h200;
    localparam logic [HOST_AW-1:0] HOST_FLAG_ADDR = 10'h201;

    // status word layout
    localparam int FLAG_C_BIT = 0;
    localparam int FLAG_AC_BIT = 1;
    localparam int FLAG_Z_BIT = 2;
    localparam int FLAG_OV_BIT = 3;
    localparam int FLAG_SC_BIT = 4;
    localparam int FLAG_CZ_BIT = 5;

    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;

    typedef enum logic [4:0] {
        op_nop,
        rotate_left_mem,
        rotate_left_to_accum,
        rotate_left_thru_carry_mem,
        rotate_left_thru_carry_to_accum,
        rotate_right_mem,
        rotate_right_to_accum,
        rotate_right_thru_carry_mem,
        rotate_right_thru_carry_to_accum,
        subtract_borrow_to_accum,
        subtract_borrow_to_mem,
        subtract_to_accum,
        subtract_to_mem,
        decrement_skip_zero_mem,
        decrement_skip_zero_to_accum,
        increment_skip_zero_mem,
        increment_skip_zero_to_accum,
        set_byte_all,
        set_bit_one,
        skip_if_nonzero_bit,
        skip_if_nonzero,
        skip_if_zero,
        nibble_exchange_mem,
        nibble_exchange_to_accum
    } opcode_e;

    typedef struct packed {
        opcode_e code;
        logic [MEM_AW-1:0] addr;
        logic [2:0] bit_sel;
    } op_s;

    typedef struct packed {
        logic carry_zero_flag;
        logic signed_zero_flag;
        logic overflow_flag;
        logic zero;
        logic aux_carry_flag;
        logic carry;
    } flags_s;

    typedef struct packed {
        logic mem_we;
        logic [DATA_W-1:0] mem_wdata;
        logic acc_we;
        logic [DATA_W-1:0] acc_wdata;
        flags_s flags;
        logic skip;
    } result_s;

endpackage : ext_dp_pkg

// File: verilog/ext_mem_datapath.sv
`timescale 1ns/1ps

// Operation
// RULE1: rotate left memory byte, bit 7 wraps to bit 0, no flags
// RULE2: rotate left through carry, old carry into bit 0, bit 7 to carry
// RULE3: rotate right memory byte, bit 0 wraps to bit 7, no flags
// RULE4: rotate right through carry, old carry into bit 7, bit 0 to carry
// RULE5: rotate accumulator forms write accumulator, memory untouched
// RULE6: subtract with borrow is acc minus byte minus inverted carry
// RULE7: subtract clears carry on negative result, sets it otherwise
// RULE8: subtracts update overflow, zero, aux carry, carry, signed-zero, carry-zero
// RULE9: memory subtract forms write the difference to the byte
// RULE10: plain subtract is acc minus byte, carry ignored
// RULE11: taken skip inserts one dummy cycle in place of next instruction
// RULE12: decrement byte, store back, skip when new value zero, no flags
// RULE13: increment byte, store back, skip when new value zero, no flags
// RULE14: accumulator inc/dec forms write acc only, skip on zero acc
// RULE15: byte set writes all ones, no flags
// RULE16: bit set forces selected bit to one, others kept, no flags
// RULE17: bit test skips when selected bit is one, no flags
// RULE18: byte zero tests read byte and write same value back
// RULE19: byte nonzero test skips when byte is nonzero
// RULE20: byte zero test skips when byte is zero
// RULE21: nibble swap exchanges byte halves in memory, no flags
// RULE22: accumulator nibble swap writes acc, memory untouched
// RULE23: every operation addresses full data memory directly, no bank
// RULE24: dummy cycle changes no register, memory or flag; here a host write in the dummy cycle still changes acc, flags or memory
module ext_mem_datapath (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire ext_dp_pkg::op_s op,
    output logic op_ready,
    output logic op_done,
    output logic skip_taken,
    input wire logic [ext_dp_pkg::HOST_AW-1:0] host_addr,
    input wire logic [ext_dp_pkg::DATA_W-1:0] host_wdata,
    input wire logic host_we,
    input wire logic host_re,
    output logic [ext_dp_pkg::DATA_W-1:0] host_rdata,
    output logic [ext_dp_pkg::DATA_W-1:0] acc,
    output ext_dp_pkg::flags_s flags
);
    import ext_dp_pkg::*;

    localparam int MEM_DEPTH = 1 << MEM_AW;

    typedef enum logic {
        st_run,
        st_dummy
    } state_e;

    function automatic logic [DATA_W-1:0] pack_flags(input flags_s f);
        logic [DATA_W-1:0] w;
        w = BYTE_ZERO;
        w[FLAG_C_BIT] = f.carry;
        w[FLAG_AC_BIT] = f.aux_carry_flag;
        w[FLAG_Z_BIT] = f.zero;
        w[FLAG_OV_BIT] = f.overflow_flag;
        w[FLAG_SC_BIT] = f.signed_zero_flag;
        w[FLAG_CZ_BIT] = f.carry_zero_flag;
        return w;
    endfunction : pack_flags

    function automatic flags_s unpack_flags(input logic [DATA_W-1:0] w);
        flags_s f;
        f.carry = w[FLAG_C_BIT];
        f.aux_carry_flag = w[FLAG_AC_BIT];
        f.zero = w[FLAG_Z_BIT];
        f.overflow_flag = w[FLAG_OV_BIT];
        f.signed_zero_flag = w[FLAG_SC_BIT];
        f.carry_zero_flag = w[FLAG_CZ_BIT];
        return f;
    endfunction : unpack_flags

    // acc - m - borrow with full flag set
    function automatic result_s subtract(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] m,
                                         input logic borrow, input logic chain_cz,
                                         input flags_s f_in);
        result_s r;
        logic [DATA_W:0] diff;
        logic [4:0] low;
        r = '0;
        diff = {1'b0, a} - {1'b0, m} - {8'h00, borrow};
        low = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, borrow};
        r.acc_wdata = diff[DATA_W-1:0];
        r.mem_wdata = diff[DATA_W-1:0];
        r.flags.carry = ~diff[DATA_W]; // see RULE7
        r.flags.aux_carry_flag = ~low[4];
        r.flags.zero = (diff[DATA_W-1:0] == BYTE_ZERO);
        r.flags.overflow_flag = (a[7] != m[7]) && (diff[7] != a[7]);
        r.flags.signed_zero_flag = r.flags.overflow_flag ^ diff[7];
        // chained borrow keeps zero only while every stage was zero
        r.flags.carry_zero_flag = chain_cz ? (r.flags.zero & f_in.carry_zero_flag)
                                           : r.flags.zero;
        return r;
    endfunction : subtract

    function automatic result_s execute(input op_s o, input logic [DATA_W-1:0] m,
                                        input logic [DATA_W-1:0] a, input flags_s f);
        result_s r;
        logic [DATA_W-1:0] v;
        r = '0;
        r.flags = f;
        v = m;
        unique case (o.code)
            op_nop: begin
            end
            rotate_left_mem, rotate_left_to_accum: begin
                v = {m[6:0], m[7]}; // see RULE1
            end
            rotate_left_thru_carry_mem, rotate_left_thru_carry_to_accum: begin
                v = {m[6:0], f.carry}; // see RULE2
                r.flags.carry = m[7];
            end
            rotate_right_mem, rotate_right_to_accum: begin
                v = {m[0], m[7:1]}; // see RULE3
            end
            rotate_right_thru_carry_mem, rotate_right_thru_carry_to_accum: begin
                v = {f.carry, m[7:1]}; // see RULE4
                r.flags.carry = m[0];
            end
            subtract_borrow_to_accum, subtract_borrow_to_mem: begin
                r = subtract(a, m, ~f.carry, 1'b1, f); // see RULE6 see RULE8
                v = r.acc_wdata;
            end
            subtract_to_accum, subtract_to_mem: begin
                r = subtract(a, m, 1'b0, 1'b0, f); // see RULE10 see RULE8
                v = r.acc_wdata;
            end
            decrement_skip_zero_mem, decrement_skip_zero_to_accum: begin
                v = m - BYTE_ONE; // see RULE12
                r.skip = (v == BYTE_ZERO);
            end
            increment_skip_zero_mem, increment_skip_zero_to_accum: begin
                v = m + BYTE_ONE; // see RULE13
                r.skip = (v == BYTE_ZERO);
            end
            set_byte_all: begin
                v = BYTE_ALL_ONES; // see RULE15
            end
            set_bit_one: begin
                v = m | (BYTE_ONE << o.bit_sel); // see RULE16
            end
            skip_if_nonzero_bit: begin
                r.skip = m[o.bit_sel]; // see RULE17
            end
            skip_if_nonzero: begin
                r.skip = (m != BYTE_ZERO); // see RULE19
            end
            skip_if_zero: begin
                r.skip = (m == BYTE_ZERO); // see RULE20
            end
            nibble_exchange_mem, nibble_exchange_to_accum: begin
                v = {m[3:0], m[7:4]}; // see RULE21
            end
            default: begin
            end
        endcase
        r.acc_wdata = v;
        r.mem_wdata = v;
        unique case (o.code)
            rotate_left_to_accum, rotate_left_thru_carry_to_accum, rotate_right_to_accum,
            rotate_right_thru_carry_to_accum, nibble_exchange_to_accum,
            subtract_borrow_to_accum, subtract_to_accum,
            decrement_skip_zero_to_accum, increment_skip_zero_to_accum: begin
                r.acc_we = 1'b1; // see RULE5 see RULE14 see RULE22
            end
            op_nop, skip_if_nonzero_bit: begin
            end
            default: begin
                // memory forms; byte tests write the byte back unchanged
                r.mem_we = 1'b1; // see RULE9 see RULE18
            end
        endcase
        return r;
    endfunction : execute

    logic [DATA_W-1:0] mem [MEM_DEPTH];
    state_e state;
    state_e next_state;
    flags_s next_flags;
    logic [DATA_W-1:0] next_acc;

    wire logic fire;
    wire logic [DATA_W-1:0] op_mem_byte;
    wire result_s res;
    wire logic host_mem_sel;
    wire logic host_acc_sel;
    wire logic host_flag_sel;
    wire logic host_mem_we;
    wire logic [DATA_W-1:0] host_read_word;

    // full address from the operation, no bank register involved
    assign op_mem_byte = mem[op.addr]; // see RULE23
    assign op_ready = (state == st_run);
    // dummy cycle takes no operation, so only a host write can change acc, flags or memory in it
    assign fire = op_valid && op_ready; // see RULE24
    assign res = execute(op, op_mem_byte, acc, flags);
    assign next_state = (fire && res.skip) ? st_dummy : st_run; // see RULE11

    assign host_mem_sel = (host_addr[HOST_AW-1] == 1'b0);
    assign host_acc_sel = (host_addr == HOST_ACC_ADDR);
    assign host_flag_sel = (host_addr == HOST_FLAG_ADDR);
    // a datapath memory write in the same cycle wins over the host
    assign host_mem_we = host_we && host_mem_sel && !(fire && res.mem_we);
    assign host_read_word = host_mem_sel ? mem[host_addr[MEM_AW-1:0]] :
                            host_acc_sel ? acc :
                            host_flag_sel ? pack_flags(flags) : BYTE_ZERO;

    assign next_acc = (fire && res.acc_we) ? res.acc_wdata :
                      (host_we && host_acc_sel) ? host_wdata : acc;
    assign next_flags = fire ? res.flags :
                        (host_we && host_flag_sel) ? unpack_flags(host_wdata) : flags;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_run;
            acc <= ACC_RESET;
            flags <= unpack_flags(FLAGS_RESET);
            op_done <= 1'b0;
            skip_taken <= 1'b0;
            host_rdata <= BYTE_ZERO;
        end else begin
            state <= next_state;
            acc <= next_acc;
            flags <= next_flags;
            op_done <= fire;
            skip_taken <= fire && res.skip; // see RULE11
            host_rdata <= host_re ? host_read_word : BYTE_ZERO;
        end
    end

    // memory array has no reset
    always_ff @(posedge ref_clk) begin
        if (fire && res.mem_we) begin
            mem[op.addr] <= res.mem_wdata;
        end else if (host_mem_we) begin
            mem[host_addr[MEM_AW-1:0]] <= host_wdata;
        end
    end

endmodule : ext_mem_datapath

// File: verification/ext_dp_chk.sv
`timescale 1ns/1ps
module ext_dp_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic skip_taken,
    input wire logic [ext_dp_pkg::HOST_AW-1:0] host_addr,
    input wire logic host_we,
    input wire logic host_re,
    input wire logic [ext_dp_pkg::DATA_W-1:0] host_rdata,
    input wire logic [ext_dp_pkg::DATA_W-1:0] acc,
    input wire ext_dp_pkg::flags_s flags
);
    import ext_dp_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire taken = op_valid && op_ready;
    done_on_take_a: assert property (taken |=> op_done)
        else $error("op_done missing after op");
    no_done_a: assert property (!taken |=> !op_done)
        else $error("op_done without op");
    skip_dummy_a: assert property (skip_taken |-> op_done && !op_ready)
        else $error("skip without refused cycle");
    one_dummy_a: assert property (skip_taken |=> op_ready && !skip_taken)
        else $error("dummy cycle too long");
    dummy_quiet_a: assert property (skip_taken && !host_we |=> $stable(acc) && $stable(flags))
        else $error("dummy cycle changed state");
    flags_hold_a: assert property (!taken && !host_we |=> $stable(flags))
        else $error("flags moved without op");
    rdata_idle_a: assert property (!host_re |=> host_rdata == 8'h00)
        else $error("read data outside read");
    acc_read_a: assert property (host_re && host_addr == HOST_ACC_ADDR |=> host_rdata == $past(acc))
        else $error("acc read wrong");
endmodule : ext_dp_chk

// File: verification/tb_top.sv
`timescale 1ns/1ps
bind ext_mem_datapath ext_dp_chk chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .op_valid(op_valid), .op_ready(op_ready), .op_done(op_done), .skip_taken(skip_taken),
    .host_addr(host_addr), .host_we(host_we), .host_re(host_re), .host_rdata(host_rdata),
    .acc(acc), .flags(flags));
module tb_top;
    import ext_dp_pkg::*;
    logic ref_clk = 0;
    logic reset_n = 0;
    logic op_valid = 0;
    logic host_we = 0;
    logic host_re = 0;
    logic re_d = 0;
    logic op_ready, op_done, skip_taken;
    op_s op = '0;
    logic [HOST_AW-1:0] host_addr = '0;
    logic [DATA_W-1:0] host_wdata = '0;
    logic [DATA_W-1:0] host_rdata, acc;
    flags_s flags;
    logic [DATA_W-1:0] m [512];
    logic [DATA_W-1:0] a = ACC_RESET;
    flags_s f = '0;
    logic [DATA_W-1:0] eq[$];
    logic [8:0] ad [4];
    int fail_count = 0;
    int compares = 0;
    int seed = 6;

    always #12.5 ref_clk = ~ref_clk;

    ext_mem_datapath dut (.ref_clk(ref_clk), .reset_n(reset_n), .op_valid(op_valid), .op(op),
        .op_ready(op_ready), .op_done(op_done), .skip_taken(skip_taken),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_we(host_we),
        .host_re(host_re), .host_rdata(host_rdata), .acc(acc), .flags(flags));

    task automatic give_verdict();
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(string n, logic [DATA_W-1:0] g);
        logic [DATA_W-1:0] e;
        e = eq.pop_front();
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one result stream: reads and op completions never overlap
    always @(posedge ref_clk) begin
        if (re_d) chk("host_rdata", host_rdata);
        if (op_done === 1'b1) chk("skip_taken", {7'h00, skip_taken});
        re_d <= host_re;
    end

    function automatic logic [DATA_W-1:0] rv();
        logic [9:0] r;
        r = 10'($random(seed));
        return r[9:8] == 2'h0 ? BYTE_ZERO : r[9:8] == 2'h1 ? BYTE_ONE :
            r[9:8] == 2'h2 ? BYTE_ALL_ONES : r[7:0];
    endfunction : rv

    function automatic logic model(opcode_e c, logic [8:0] x, logic [2:0] bs);
        logic [7:0] b, r;
        logic [8:0] d;
        logic [4:0] h;
        logic bf, bin, s;
        b = m[x];
        s = 1'b0;
        bf = c inside {subtract_borrow_to_accum, subtract_borrow_to_mem};
        bin = bf & ~f.carry;
        d = {1'b0, a} - {1'b0, b} - 9'(bin);
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bin);
        r = d[7:0];
        if (bf || c inside {subtract_to_accum, subtract_to_mem}) begin
            f.overflow_flag = (a[7] ^ b[7]) & (a[7] ^ r[7]);
            f.signed_zero_flag = f.overflow_flag ^ r[7];
            f.carry_zero_flag = (r == 8'h00) & (~bf | f.carry_zero_flag);
            f.zero = r == 8'h00;
            f.aux_carry_flag = ~h[4];
            f.carry = ~d[8];
        end
        case (c)
            rotate_left_mem: m[x] = {b[6:0], b[7]};
            rotate_left_to_accum: a = {b[6:0], b[7]};
            rotate_left_thru_carry_mem: m[x] = {b[6:0], f.carry};
            rotate_left_thru_carry_to_accum: a = {b[6:0], f.carry};
            rotate_right_mem: m[x] = {b[0], b[7:1]};
            rotate_right_to_accum: a = {b[0], b[7:1]};
            rotate_right_thru_carry_mem: m[x] = {f.carry, b[7:1]};
            rotate_right_thru_carry_to_accum: a = {f.carry, b[7:1]};
            subtract_borrow_to_mem, subtract_to_mem: m[x] = r;
            subtract_borrow_to_accum, subtract_to_accum: a = r;
            decrement_skip_zero_mem: m[x] = b - 8'h01;
            decrement_skip_zero_to_accum: a = b - 8'h01;
            increment_skip_zero_mem: m[x] = b + 8'h01;
            increment_skip_zero_to_accum: a = b + 8'h01;
            set_byte_all: m[x] = BYTE_ALL_ONES;
            set_bit_one: m[x][bs] = 1'b1;
            skip_if_nonzero_bit: s = b[bs];
            skip_if_nonzero: s = b != 8'h00;
            skip_if_zero: s = b == 8'h00;
            nibble_exchange_mem: m[x] = {b[3:0], b[7:4]};
            nibble_exchange_to_accum: a = {b[3:0], b[7:4]};
            default: ;
        endcase
        if (c inside {rotate_left_thru_carry_mem, rotate_left_thru_carry_to_accum}) f.carry = b[7];
        if (c inside {rotate_right_thru_carry_mem, rotate_right_thru_carry_to_accum}) f.carry = b[0];
        if (c inside {decrement_skip_zero_mem, increment_skip_zero_mem}) s = m[x] == 8'h00;
        if (c inside {decrement_skip_zero_to_accum, increment_skip_zero_to_accum}) s = a == 8'h00;
        return s;
    endfunction : model

    task automatic hw(logic [HOST_AW-1:0] x, logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        host_we <= 1'b1;
        host_addr <= x;
        host_wdata <= d;
        if (x < HOST_ACC_ADDR) m[x[8:0]] = d;
        else if (x == HOST_ACC_ADDR) a = d;
        else if (x == HOST_FLAG_ADDR) f = d[5:0];
        @(posedge ref_clk);
        host_we <= 1'b0;
    endtask : hw

    task automatic hr(logic [HOST_AW-1:0] x);
        @(posedge ref_clk);
        host_re <= 1'b1;
        host_addr <= x;
        eq.push_back(x < HOST_ACC_ADDR ? m[x[8:0]] : x == HOST_ACC_ADDR ? a :
            x == HOST_FLAG_ADDR ? {2'b00, f} : 8'h00);
        @(posedge ref_clk);
        host_re <= 1'b0;
    endtask : hr

    // valid stays up so back-to-back ops meet the refused dummy cycle
    task automatic do_op(opcode_e c, logic [8:0] x, logic [2:0] bs);
        op_valid <= 1'b1;
        op <= '{c, x, bs};
        do @(negedge ref_clk); while (op_ready !== 1'b1);
        eq.push_back({7'h00, model(c, x, bs)});
        @(posedge ref_clk);
    endtask : do_op

    initial begin
        #(25 * 40000);
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        hr(HOST_FLAG_ADDR);
        hw(10'h3ff, 8'h5a);
        hr(10'h3ff);
        hr(HOST_ACC_ADDR);
        for (int r = 0; r < 8; r++) begin
            for (int i = 1; i < 24; i++) begin
                ad[0] = 9'($random(seed));
                hw({1'b0, ad[0]}, rv());
                hw(HOST_ACC_ADDR, rv());
                hw(HOST_FLAG_ADDR, 8'($random(seed)));
                do_op(opcode_e'(i), ad[0], 3'($random(seed)));
                op_valid <= 1'b0;
                hr({1'b0, ad[0]});
                hr(HOST_ACC_ADDR);
                hr(HOST_FLAG_ADDR);
            end
        end
        // every byte the mixed run touches is loaded first, so no unknown reaches the skip logic
        for (int k = 0; k < 4; k++) begin
            ad[k] = 9'($random(seed));
            hw({1'b0, ad[k]}, rv());
        end
        for (int n = 0; n < 80; n++)
            do_op(opcode_e'(5'(1 + {$random(seed)} % 23)), ad[n % 4], 3'($random(seed)));
        op_valid <= 1'b0;
        for (int k = 0; k < 4; k++) hr({1'b0, ad[k]});
        hr(HOST_ACC_ADDR);
        hr(HOST_FLAG_ADDR);
        repeat (3) @(posedge ref_clk);
        give_verdict();
    end
endmodule : tb_top
